// ===== rtl/cfs_regs.sv
// The AXI4-Lite interface to the registers was decided locally.
module cfs_regs (
    input  wire logic                          REF_CLK_IN,
    input  wire logic                          SYS_RST_IN,
    input  wire logic [cfs_pkg::N_CELLS-1:0]   BAL_SWITCH_CMD_IN,
    input  wire logic [cfs_pkg::N_PINS-1:0]    PIN_FAULT_RAW_IN,
    input  wire logic [cfs_pkg::N_CELLS-1:0]   UV_CMP_RAW_IN,
    input  wire logic                          S_AXI_AWVALID_IN,
    output logic                               S_AXI_AWREADY_OUT,
    input  wire logic [cfs_pkg::ADDR_W-1:0]    S_AXI_AWADDR_IN,
    input  wire logic [2:0]                    S_AXI_AWPROT_IN,
    input  wire logic                          S_AXI_WVALID_IN,
    output logic                               S_AXI_WREADY_OUT,
    input  wire logic [cfs_pkg::DATA_W-1:0]    S_AXI_WDATA_IN,
    input  wire logic [3:0]                    S_AXI_WSTRB_IN,
    output logic                               S_AXI_BVALID_OUT,
    input  wire logic                          S_AXI_BREADY_IN,
    output logic      [1:0]                    S_AXI_BRESP_OUT,
    input  wire logic                          S_AXI_ARVALID_IN,
    output logic                               S_AXI_ARREADY_OUT,
    input  wire logic [cfs_pkg::ADDR_W-1:0]    S_AXI_ARADDR_IN,
    input  wire logic [2:0]                    S_AXI_ARPROT_IN,
    output logic                               S_AXI_RVALID_OUT,
    input  wire logic                          S_AXI_RREADY_IN,
    output logic      [cfs_pkg::DATA_W-1:0]    S_AXI_RDATA_OUT,
    output logic      [1:0]                    S_AXI_RRESP_OUT,
    output logic                               IRQ_OUT
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                                aw_have;
        logic [cfs_pkg::ADDR_W-1:0]          aw_addr;
        logic                                w_have;
        logic [cfs_pkg::DATA_W-1:0]          w_data;
        logic [3:0]                          w_strb;
        logic                                bvalid;
        logic [1:0]                          bresp;
        logic                                rvalid;
        logic [cfs_pkg::DATA_W-1:0]          rdata;
        logic [1:0]                          rresp;
        logic [cfs_pkg::STAT_W-1:0]          bal;
        logic [cfs_pkg::STAT_W-1:0]          pin;
        logic [cfs_pkg::STAT_W-1:0]          uv;
        logic [cfs_pkg::N_CELLS-1:0]         comp_en;
        logic [cfs_pkg::N_PINS*2-1:0]        pin_cfg;
        logic [cfs_pkg::INT_W-1:0]           int_stat;
        logic [cfs_pkg::INT_W-1:0]           int_mask;
        logic                                irq;
    } cfs_state_t;

    cfs_state_t                     st_reg;
    cfs_state_t                     st_next;
    logic [cfs_pkg::N_PINS-1:0]     pin_sync;
    logic [cfs_pkg::N_CELLS-1:0]    uv_sync;
    logic [cfs_pkg::N_PINS-1:0]     pin_valid;
    logic                           aw_hs;
    logic                           w_hs;
    logic                           ar_hs;

    // ------------------------------------------------------------------
    // pin and comparator inputs cross in through two flops
    // ------------------------------------------------------------------
    cfs_sync #(
        .WIDTH (cfs_pkg::N_PINS)
    ) u_pin_sync (
        .clk_in (REF_CLK_IN),
        .rst_in (SYS_RST_IN),
        .d_in   (PIN_FAULT_RAW_IN),
        .q_out  (pin_sync)
    );

    cfs_sync #(
        .WIDTH (cfs_pkg::N_CELLS)
    ) u_uv_sync (
        .clk_in (REF_CLK_IN),
        .rst_in (SYS_RST_IN),
        .d_in   (UV_CMP_RAW_IN),
        .q_out  (uv_sync)
    );

    // ------------------------------------------------------------------
    // fault select decode
    // ------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < cfs_pkg::N_PINS; i++) begin
            pin_valid[i] = (st_reg.pin_cfg[2*i +: 2] == cfs_pkg::FAULT_ENABLE_SELECT_LOW)
                        || (st_reg.pin_cfg[2*i +: 2] == cfs_pkg::FAULT_ENABLE_SELECT_HIGH);
        end
    end

    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    assign aw_hs = S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT;
    assign w_hs  = S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
    assign ar_hs = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [cfs_pkg::INT_W-1:0]  events;
        logic [cfs_pkg::INT_W-1:0]  clr;
        logic [31:0]                merged;
        events  = '0;
        clr     = '0;
        merged  = '0;
        st_next = st_reg;

        // status sampling; flags are live levels, not latched
        st_next.bal = {2'h0, BAL_SWITCH_CMD_IN};
        st_next.pin = {2'h0, pin_sync & pin_valid};
        st_next.uv  = {2'h0, uv_sync & st_reg.comp_en};

        // a new fault (rising flag) is the interrupt event
        events[cfs_pkg::INT_PIN_LSB +: cfs_pkg::N_PINS]
            = st_next.pin[cfs_pkg::N_PINS-1:0] & ~st_reg.pin[cfs_pkg::N_PINS-1:0];
        events[cfs_pkg::INT_UV_LSB +: cfs_pkg::N_CELLS]
            = st_next.uv[cfs_pkg::N_CELLS-1:0] & ~st_reg.uv[cfs_pkg::N_CELLS-1:0];

        // write channel
        if (st_reg.bvalid && S_AXI_BREADY_IN) begin
            st_next.bvalid = 1'b0;
        end
        if (!st_reg.bvalid && st_reg.aw_have && st_reg.w_have) begin
            st_next.aw_have = 1'b0;
            st_next.w_have  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = cfs_pkg::RESP_OKAY;
            case (st_reg.aw_addr[cfs_pkg::ADDR_W-1:2])
                cfs_pkg::IDX_COMP_EN: begin
                    merged = lane_merge({26'h0, st_reg.comp_en}, st_reg.w_data,
                                        st_reg.w_strb);
                    st_next.comp_en = merged[cfs_pkg::N_CELLS-1:0];
                end
                cfs_pkg::IDX_PIN_CFG: begin
                    merged = lane_merge({20'h0, st_reg.pin_cfg}, st_reg.w_data,
                                        st_reg.w_strb);
                    st_next.pin_cfg = merged[cfs_pkg::N_PINS*2-1:0];
                end
                cfs_pkg::IDX_INT_MASK: begin
                    merged = lane_merge({18'h0, st_reg.int_mask}, st_reg.w_data,
                                        st_reg.w_strb);
                    st_next.int_mask = merged[cfs_pkg::INT_W-1:0];
                end
                // status registers accept the write and keep their value
                cfs_pkg::IDX_BAL_STATE,
                cfs_pkg::IDX_PIN_FAULT,
                cfs_pkg::IDX_UV_FLAGS,
                cfs_pkg::IDX_INT_STAT: begin
                    st_next.bresp = cfs_pkg::RESP_OKAY;
                end
                default: begin
                    st_next.bresp = cfs_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (aw_hs) begin
            st_next.aw_have = 1'b1;
            st_next.aw_addr = S_AXI_AWADDR_IN;
        end
        if (w_hs) begin
            st_next.w_have = 1'b1;
            st_next.w_data = S_AXI_WDATA_IN;
            st_next.w_strb = S_AXI_WSTRB_IN;
        end

        // read channel
        if (st_reg.rvalid && S_AXI_RREADY_IN) begin
            st_next.rvalid = 1'b0;
        end
        if (ar_hs) begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = cfs_pkg::RESP_OKAY;
            st_next.rdata  = '0;
            case (S_AXI_ARADDR_IN[cfs_pkg::ADDR_W-1:2])
                cfs_pkg::IDX_BAL_STATE: st_next.rdata = {24'h0, st_reg.bal};
                cfs_pkg::IDX_PIN_FAULT: st_next.rdata = {24'h0, st_reg.pin};
                cfs_pkg::IDX_UV_FLAGS:  st_next.rdata = {24'h0, st_reg.uv};
                cfs_pkg::IDX_COMP_EN:   st_next.rdata = {26'h0, st_reg.comp_en};
                cfs_pkg::IDX_PIN_CFG:   st_next.rdata = {20'h0, st_reg.pin_cfg};
                cfs_pkg::IDX_INT_MASK:  st_next.rdata = {18'h0, st_reg.int_mask};
                cfs_pkg::IDX_INT_STAT: begin
                    st_next.rdata = {18'h0, st_reg.int_stat};
                    clr           = st_reg.int_stat;
                end
                default: begin
                    st_next.rresp = cfs_pkg::RESP_SLVERR;
                end
            endcase
        end

        // read clears; an event in the same cycle survives the clear
        st_next.int_stat = (st_reg.int_stat & ~clr) | events;
        st_next.irq      = |(st_next.int_stat & st_next.int_mask);
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // one write and one read in flight at most keeps the slave tiny
    assign S_AXI_AWREADY_OUT = !st_reg.aw_have && !st_reg.bvalid;
    assign S_AXI_WREADY_OUT  = !st_reg.w_have && !st_reg.bvalid;
    assign S_AXI_BVALID_OUT  = st_reg.bvalid;
    assign S_AXI_BRESP_OUT   = st_reg.bresp;
    assign S_AXI_ARREADY_OUT = !st_reg.rvalid;
    assign S_AXI_RVALID_OUT  = st_reg.rvalid;
    assign S_AXI_RDATA_OUT   = st_reg.rdata;
    assign S_AXI_RRESP_OUT   = st_reg.rresp;
    assign IRQ_OUT           = st_reg.irq;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic [cfs_pkg::STAT_W-1:0]     bal_q;
    logic [cfs_pkg::STAT_W-1:0]     pin_q;
    logic [cfs_pkg::STAT_W-1:0]     uv_q;
    logic [cfs_pkg::N_CELLS-1:0]    comp_q;
    logic [cfs_pkg::INT_W-1:0]      istat_q;
    logic                           rd_bal;
    logic                           rd_uv;
    logic                           rd_ist;
    logic                           wr_uv;

    assign bal_q   = st_reg.bal;
    assign pin_q   = st_reg.pin;
    assign uv_q    = st_reg.uv;
    assign comp_q  = st_reg.comp_en;
    assign istat_q = st_reg.int_stat;
    assign rd_bal  = ar_hs && (S_AXI_ARADDR_IN == cfs_pkg::ADDR_BAL_STATE);
    assign rd_uv   = ar_hs && (S_AXI_ARADDR_IN == cfs_pkg::ADDR_UV_FLAGS);
    assign rd_ist  = ar_hs && (S_AXI_ARADDR_IN == cfs_pkg::ADDR_INT_STAT);
    assign wr_uv   = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid
                  && (st_reg.aw_addr == cfs_pkg::ADDR_UV_FLAGS);

    default clocking cfs_cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);

    bal_follow_a: assert property (
        rd_bal |=> S_AXI_RVALID_OUT && S_AXI_RDATA_OUT == {24'h0, $past(bal_q)}
            && bal_q[5:0] == $past(BAL_SWITCH_CMD_IN))
        else $error("balance state read mismatch");

    pin_fault_a: assert property (
        ##1 pin_q[5:0] == $past(pin_sync & pin_valid))
        else $error("pin fault flag does not follow synced input");

    pin_gate_a: assert property (
        (pin_q[5:0] & ~$past(pin_valid)) == 6'h00)
        else $error("pin fault flag set with invalid fault select");

    uv_flag_a: assert property (
        ##1 uv_q[5:0] == $past(uv_sync & comp_q))
        else $error("under-voltage flag does not follow comparator");

    uv_gate_a: assert property (
        (uv_q[5:0] & ~$past(comp_q)) == 6'h00)
        else $error("under-voltage flag set with comparator disabled");

    uv_addr_a: assert property (
        rd_uv |=> S_AXI_RRESP_OUT == cfs_pkg::RESP_OKAY
            && S_AXI_RDATA_OUT == {24'h0, $past(uv_q)})
        else $error("under-voltage register read mismatch");

    status_ro_a: assert property (
        wr_uv |=> S_AXI_BVALID_OUT && S_AXI_BRESP_OUT == cfs_pkg::RESP_OKAY
            && bal_q[7:6] == 2'h0 && pin_q[7:6] == 2'h0 && uv_q[7:6] == 2'h0)
        else $error("status write or reserved bits misbehave");

    reset_zero_a: assert property (
        $past(SYS_RST_IN) |-> bal_q == cfs_pkg::STAT_RESET
            && pin_q == cfs_pkg::STAT_RESET && uv_q == cfs_pkg::STAT_RESET)
        else $error("status registers not zero after reset");

    stat_clear_a: assert property (
        rd_ist |=> S_AXI_RDATA_OUT == {18'h0, $past(istat_q)}
            && (istat_q & ~{uv_q[5:0] & ~$past(uv_q[5:0]), 2'h0,
                            pin_q[5:0] & ~$past(pin_q[5:0])}) == 14'h0000)
        else $error("interrupt status read mismatch");

    irq_level_a: assert property (
        ##1 IRQ_OUT == |(istat_q & st_reg.int_mask))
        else $error("interrupt level does not match masked status");

    rsvd_zero_a: assert property (
        bal_q[7:6] == 2'h0 && pin_q[7:6] == 2'h0 && uv_q[7:6] == 2'h0)
        else $error("reserved status bits not zero");

    // a write to the under-voltage flags must not leak into a writable register through the decode
    status_keep_a: assert property (
        wr_uv |=> $stable(comp_q) && $stable(st_reg.pin_cfg) && $stable(st_reg.int_mask))
        else $error("status write changed a setting");

    // ------------------------------------------------------------------
    // bus answer timing
    // ------------------------------------------------------------------
    // the latency is fixed here, but masters must still wait on valid
    write_answer_a: assert property (
        st_reg.aw_have && st_reg.w_have && !st_reg.bvalid
            |=> S_AXI_BVALID_OUT && !S_AXI_AWREADY_OUT && !S_AXI_WREADY_OUT)
        else $error("write response late or ready not withdrawn");

    read_answer_a: assert property (
        ar_hs |=> S_AXI_RVALID_OUT && !S_AXI_ARREADY_OUT)
        else $error("read data late or ready not withdrawn");

    write_cov_c: cover property (aw_hs ##[1:8] S_AXI_BVALID_OUT && S_AXI_BREADY_IN);
    uv_read_c:   cover property (rd_uv ##1 S_AXI_RDATA_OUT[0]);
    irq_rise_c:  cover property (!IRQ_OUT ##1 IRQ_OUT);
    pin_gate_c:  cover property (pin_sync[0] && !pin_valid[0]);
    uv_gate_c:   cover property (uv_sync[0] && !comp_q[0]);

endmodule

// ===== rtl/cfs_pkg.sv
package cfs_pkg;

    // ------------------------------------------------------------------
    // bus geometry, channel counts and field widths
    // ------------------------------------------------------------------
    localparam int         DATA_W      = 32;
    localparam int         ADDR_W      = 12;
    localparam int         IDX_W       = 10;
    localparam int         N_CELLS     = 6;
    localparam int         N_PINS      = 6;
    localparam int         CFG_W       = 2;
    localparam int         STAT_W      = 8;
    localparam int         INT_W       = 14;

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_BAL_STATE = 10'h28F;
    localparam logic [IDX_W-1:0] IDX_PIN_FAULT = 10'h290;
    localparam logic [IDX_W-1:0] IDX_UV_FLAGS  = 10'h291;
    localparam logic [IDX_W-1:0] IDX_COMP_EN   = 10'h2A0;
    localparam logic [IDX_W-1:0] IDX_PIN_CFG   = 10'h2A1;
    localparam logic [IDX_W-1:0] IDX_INT_STAT  = 10'h2A2;
    localparam logic [IDX_W-1:0] IDX_INT_MASK  = 10'h2A3;

    localparam logic [ADDR_W-1:0] ADDR_BAL_STATE = {IDX_BAL_STATE, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_PIN_FAULT = {IDX_PIN_FAULT, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_UV_FLAGS  = {IDX_UV_FLAGS, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_INT_STAT  = {IDX_INT_STAT, 2'h0};

    // ------------------------------------------------------------------
    // field values and reset values
    // ------------------------------------------------------------------
    localparam logic [CFG_W-1:0]  FAULT_ENABLE_SELECT_LOW    = 2'h1;
    localparam logic [CFG_W-1:0]  FAULT_ENABLE_SELECT_HIGH   = 2'h2;
    localparam logic [STAT_W-1:0] STAT_RESET    = 8'h00;
    localparam int                INT_PIN_LSB   = 0;
    localparam int                INT_UV_LSB    = 8;
    localparam logic [1:0]        RESP_OKAY     = 2'h0;
    localparam logic [1:0]        RESP_SLVERR   = 2'h2;

endpackage

// ===== rtl/cfs_sync.sv
module cfs_sync #(
    parameter int WIDTH = 6
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);

    // ------------------------------------------------------------------
    // two flop synchroniser; first stage feeds only the second
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } cfs_sync_state_t;

    cfs_sync_state_t st_reg;
    cfs_sync_state_t st_next;

    always_comb begin
        st_next        = st_reg;
        st_next.stage1 = d_in;
        st_next.stage2 = st_reg.stage1;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q_out = st_reg.stage2;

endmodule

// ===== tb/cfs_regs_test.sv
module cfs_regs_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------------
    logic        clk;
    logic        rst;
    logic [5:0]  bal_cmd;
    logic [5:0]  pin_raw;
    logic [5:0]  uv_raw;
    logic        awvalid;
    logic        awready;
    logic [11:0] awaddr;
    logic        wvalid;
    logic        wready;
    logic [31:0] wdata;
    logic        bvalid;
    logic        bready;
    logic [1:0]  bresp;
    logic        arvalid;
    logic        arready;
    logic [11:0] araddr;
    logic        rvalid;
    logic        rready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        irq;
    int          errors;
    int          n_checks;
    int          cycles;
    logic [31:0] d;
    logic [1:0]  r;
    logic [5:0]  pats [6] = '{6'h01, 6'h20, 6'h2A, 6'h15, 6'h3F, 6'h00};

    localparam logic [11:0] A_COMP = {cfs_pkg::IDX_COMP_EN, 2'h0};
    localparam logic [11:0] A_PCFG = {cfs_pkg::IDX_PIN_CFG, 2'h0};
    localparam logic [11:0] A_MASK = {cfs_pkg::IDX_INT_MASK, 2'h0};

    cfs_regs i_dut (
        .REF_CLK_IN        (clk),
        .SYS_RST_IN        (rst),
        .BAL_SWITCH_CMD_IN (bal_cmd),
        .PIN_FAULT_RAW_IN  (pin_raw),
        .UV_CMP_RAW_IN     (uv_raw),
        .S_AXI_AWVALID_IN  (awvalid),
        .S_AXI_AWREADY_OUT (awready),
        .S_AXI_AWADDR_IN   (awaddr),
        .S_AXI_AWPROT_IN   (3'h0),
        .S_AXI_WVALID_IN   (wvalid),
        .S_AXI_WREADY_OUT  (wready),
        .S_AXI_WDATA_IN    (wdata),
        .S_AXI_WSTRB_IN    (4'hF),
        .S_AXI_BVALID_OUT  (bvalid),
        .S_AXI_BREADY_IN   (bready),
        .S_AXI_BRESP_OUT   (bresp),
        .S_AXI_ARVALID_IN  (arvalid),
        .S_AXI_ARREADY_OUT (arready),
        .S_AXI_ARADDR_IN   (araddr),
        .S_AXI_ARPROT_IN   (3'h0),
        .S_AXI_RVALID_OUT  (rvalid),
        .S_AXI_RREADY_IN   (rready),
        .S_AXI_RDATA_OUT   (rdata),
        .S_AXI_RRESP_OUT   (rresp),
        .IRQ_OUT           (irq)
    );

    // ------------------------------------------------------------------
    // clock, hang guard
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // generous ceiling: the whole sequence needs a few hundred cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors = errors + 1;
            summarize();
        end
    end

    // ------------------------------------------------------------------
    // report helpers
    // ------------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("unexpected at %0t: data %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("unexpected at %0t: resp %h expected %h", $time, got, exp);
        end
    endtask

    // ------------------------------------------------------------------
    // bus tasks: address and data offered together, released when taken
    // ------------------------------------------------------------------
    task automatic axi_write(input logic [11:0] a, input logic [31:0] dat,
                             output logic [1:0] resp);
        bit aw_done;
        bit w_done;
        aw_done = 0;
        w_done = 0;
        awaddr  <= a;
        wdata   <= dat;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic axi_read(input logic [11:0] a, output logic [31:0] dat,
                            output logic [1:0] resp);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        dat = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask

    // read and compare both data and response
    task automatic expect_read(input logic [11:0] a, input logic [31:0] exp,
                               input logic [1:0] exp_resp);
        logic [31:0] got;
        logic [1:0]  rs;
        axi_read(a, got, rs);
        check_data(got, exp);
        check_resp(rs, exp_resp);
    endtask

    // flags pass two sync flops and a flag register
    task automatic settle();
        repeat (6) @(posedge clk);
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        errors = 0;
        n_checks = 0;
        cycles = 0;
        rst = 1'b1;
        bal_cmd = 6'h00;
        pin_raw = 6'h00;
        uv_raw = 6'h00;
        awvalid = 1'b0;
        awaddr = 12'h000;
        wvalid = 1'b0;
        wdata = 32'h0;
        bready = 1'b0;
        arvalid = 1'b0;
        araddr = 12'h000;
        rready = 1'b0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);

        // reset values, all zero
        expect_read(cfs_pkg::ADDR_BAL_STATE, 32'h0, cfs_pkg::RESP_OKAY);
        expect_read(cfs_pkg::ADDR_PIN_FAULT, 32'h0, cfs_pkg::RESP_OKAY);
        expect_read(12'hA44, 32'h0, cfs_pkg::RESP_OKAY);

        // writes to status registers are accepted but change nothing
        bal_cmd <= 6'h00;
        axi_write(cfs_pkg::ADDR_BAL_STATE, 32'hFFFFFFFF, r);
        check_resp(r, cfs_pkg::RESP_OKAY);
        axi_write(cfs_pkg::ADDR_PIN_FAULT, 32'hFFFFFFFF, r);
        axi_write(12'hA44, 32'hFFFFFFFF, r);
        expect_read(cfs_pkg::ADDR_BAL_STATE, 32'h0, cfs_pkg::RESP_OKAY);
        expect_read(cfs_pkg::ADDR_PIN_FAULT, 32'h0, cfs_pkg::RESP_OKAY);
        expect_read(12'hA44, 32'h0, cfs_pkg::RESP_OKAY);

        // unmapped place
        axi_write(12'hFFC, 32'h12345678, r);
        check_resp(r, cfs_pkg::RESP_SLVERR);
        expect_read(12'hFFC, 32'h0, cfs_pkg::RESP_SLVERR);

        // balancing switch status follows each of the six command patterns in pats
        foreach (pats[i]) begin
            bal_cmd <= pats[i];
            settle();
            expect_read(cfs_pkg::ADDR_BAL_STATE, {26'h0, pats[i]}, cfs_pkg::RESP_OKAY);
        end

        // pin faults: all four select codes; 00 and 11 must read zero
        pin_raw <= 6'h3F;
        settle();
        expect_read(cfs_pkg::ADDR_PIN_FAULT, 32'h0, cfs_pkg::RESP_OKAY);
        axi_write(A_PCFG, 32'h000009E4, r);
        settle();
        expect_read(cfs_pkg::ADDR_PIN_FAULT, 32'h36, cfs_pkg::RESP_OKAY);
        check_data({31'h0, irq}, 32'h0); // mask still zero
        axi_write(A_MASK, 32'h36, r);
        settle();
        check_data({31'h0, irq}, 32'h1);
        expect_read(cfs_pkg::ADDR_INT_STAT, 32'h36, cfs_pkg::RESP_OKAY);
        settle();
        check_data({31'h0, irq}, 32'h0);
        pin_raw <= 6'h00;
        settle();
        expect_read(cfs_pkg::ADDR_PIN_FAULT, 32'h0, cfs_pkg::RESP_OKAY);

        // under-voltage: only enabled comparators report, at byte 0xA44
        uv_raw <= 6'h3F;
        settle();
        expect_read(12'hA44, 32'h0, cfs_pkg::RESP_OKAY);
        axi_write(A_COMP, 32'h0F, r);
        settle();
        expect_read(12'hA44, 32'h0F, cfs_pkg::RESP_OKAY);
        check_data({31'h0, irq}, 32'h0); // uv events are masked
        expect_read(cfs_pkg::ADDR_INT_STAT, 32'h0F00, cfs_pkg::RESP_OKAY);
        expect_read(cfs_pkg::ADDR_INT_STAT, 32'h0, cfs_pkg::RESP_OKAY);
        uv_raw <= 6'h21;
        settle();
        expect_read(12'hA44, 32'h01, cfs_pkg::RESP_OKAY);

        // mid-run reset with uv and balance inputs still active: pin and uv status restart from zero, balance state reads the live command
        bal_cmd <= 6'h3F;
        settle();
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        expect_read(12'hA44, 32'h0, cfs_pkg::RESP_OKAY);
        expect_read(cfs_pkg::ADDR_PIN_FAULT, 32'h0, cfs_pkg::RESP_OKAY);
        expect_read(cfs_pkg::ADDR_BAL_STATE, 32'h3F, cfs_pkg::RESP_OKAY);
        summarize();
    end
endmodule
